// ---- core/tamper_pkg.sv ----
/*
 * Constants for the tamper detector with backup data store.
 * Assumes an APB master with 32-bit data and one register per aligned word.
 */
// How it works
// - Pin-enable 0 turns detection off and frees the pin for general use.
// - Polarity 0 makes a high pin level active; 1 makes low active.
// - An active level on the enabled pin clears every backup data register.
// - Event flag sets on every tamper event regardless of interrupt enable.
// - Interrupt flag sets on a tamper event only while interrupt enable is 1.
// - Interrupt flag resets only by software clear, system reset or Standby exit.
// - Interrupt enable bit gates tamper interrupt generation; irq_o rises on any tamper event when irq_mask bit 0 is set.
// - Tamper interrupt never wakes the core from low-power modes.
// - Writing 1 to the interrupt clear bit clears the interrupt flag.
// - Writing 1 to the event clear bit clears the event flag.
// - Forty-two 16-bit backup registers, cleared by domain reset or tamper.
// - Tamper is unavailable while the pin outputs alarm, second or clock.
package tamper_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int          NUM_BACKUP            = 42;
   localparam int          DATA_W                = 16;
   localparam logic [11:0] ADDR_BACKUP_FIRST     = 12'h004;
   localparam logic [11:0] ADDR_TAMPER_CONTROL   = 12'h0B0;
   localparam logic [11:0] ADDR_TAMPER_CTRL_STS  = 12'h0B4;
   localparam logic [11:0] ADDR_IRQ_STATUS       = 12'h0C0;
   localparam logic [11:0] ADDR_IRQ_MASK         = 12'h0C4;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          BIT_PIN_ENABLE        = 0;
   localparam int          BIT_POLARITY          = 1;
   localparam int          BIT_EVENT_CLEAR       = 0;
   localparam int          BIT_IRQ_CLEAR         = 1;
   localparam int          BIT_IRQ_ENABLE        = 2;
   localparam int          BIT_EVENT_FLAG        = 8;
   localparam int          BIT_IRQ_FLAG          = 9;
   localparam logic [15:0] RESET_BACKUP          = 16'h0000;
   localparam logic [1:0]  RESET_CONTROL         = 2'h0;

endpackage

// ---- core/tamper_detect_backup_clear.sv ----
/*
 * Tamper detector with backup data registers, interrupt status and mask.
 * Assumes tamper pin is synchronous to ref_clk_i and an APB master.
 */
// Decided for this implementation: the placing of the registers and the APB register port.
module tamper_detect_backup_clear
   import tamper_pkg::*;
#(
   parameter int NUM_REGS = NUM_BACKUP
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        nrst_backup_i,
   input  wire logic        standby_exit_i,
   input  wire logic        pin_output_busy_i,
   input  wire logic        tamper_pin_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             pin_gpio_free_o,
   output logic             tamper_irq_o,
   output logic             irq_o
);

   initial
   begin
      if (NUM_REGS < 1 || NUM_REGS > 44)
         $error("NUM_REGS out of range");
   end

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic                           wr;
   logic                           rd;
   logic                           is_backup;
   logic [11:0]                    backup_off;
   logic [5:0]                     backup_idx;
   logic                           hit_ctrl;
   logic                           hit_cs;
   logic                           hit_st;
   logic                           hit_mask;
   logic                           mapped;

   assign wr         = psel_i & penable_i & pwrite_i;
   assign rd         = psel_i & penable_i & ~pwrite_i;
   assign backup_off = paddr_i - ADDR_BACKUP_FIRST;
   assign backup_idx = backup_off[7:2];
   assign is_backup  = (paddr_i[1:0] == 2'h0) && (paddr_i >= ADDR_BACKUP_FIRST)
                       && (backup_off[11:2] < 10'(NUM_REGS));
   assign hit_ctrl   = paddr_i == ADDR_TAMPER_CONTROL;
   assign hit_cs     = paddr_i == ADDR_TAMPER_CTRL_STS;
   assign hit_st     = paddr_i == ADDR_IRQ_STATUS;
   assign hit_mask   = paddr_i == ADDR_IRQ_MASK;
   assign mapped     = is_backup | hit_ctrl | hit_cs | hit_st | hit_mask;
   assign pready_o   = 1'b1;
   assign pslverr_o  = psel_i & penable_i & ~mapped;

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic                           pin_enable;
   logic                           polarity;
   logic                           irq_enable;

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_backup_i)
      begin
         pin_enable <= RESET_CONTROL[BIT_PIN_ENABLE];
         polarity   <= RESET_CONTROL[BIT_POLARITY];
      end
      else if (wr && hit_ctrl)
      begin
         pin_enable <= pwdata_i[BIT_PIN_ENABLE];
         polarity   <= pwdata_i[BIT_POLARITY];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_backup_i)
         irq_enable <= 1'b0;
      else if (wr && hit_cs)
         irq_enable <= pwdata_i[BIT_IRQ_ENABLE];
   end

   // ------------------------------------------------------------
   // Detection
   // ------------------------------------------------------------
   logic                           active_level;
   logic                           tamper_event;

   assign pin_gpio_free_o = ~pin_enable;
   assign active_level    = tamper_pin_i ^ polarity;
   assign tamper_event    = pin_enable & ~pin_output_busy_i & active_level;

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   logic                           event_flag;
   logic                           irq_flag;

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_backup_i)
         event_flag <= 1'b0;
      else if (tamper_event)
         event_flag <= 1'b1;
      else if (wr && hit_cs && pwdata_i[BIT_EVENT_CLEAR])
         event_flag <= 1'b0;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || standby_exit_i)
         irq_flag <= 1'b0;
      else if (tamper_event && irq_enable)
         irq_flag <= 1'b1;
      else if (wr && hit_cs && pwdata_i[BIT_IRQ_CLEAR])
         irq_flag <= 1'b0;
   end

   // No wake-up path exists; the request is a plain level
   assign tamper_irq_o = irq_flag;

   // ------------------------------------------------------------
   // Backup data store
   // ------------------------------------------------------------
   logic [DATA_W-1:0]              backup [NUM_REGS];

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_backup_i || tamper_event)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            backup[i] <= RESET_BACKUP;
      end
      else if (wr && is_backup)
         backup[backup_idx] <= pwdata_i[DATA_W-1:0];
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   logic [1:0]                     irq_status;
   logic [1:0]                     irq_mask;
   logic [1:0]                     next_irq_status;

   always_comb
   begin
      next_irq_status = irq_status;
      if (wr && hit_st)
         next_irq_status = irq_status & ~pwdata_i[1:0];
      if (tamper_event)
         next_irq_status[0] = 1'b1;
      if (tamper_event && irq_enable)
         next_irq_status[1] = 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         irq_status <= 2'h0;
      else
         irq_status <= next_irq_status;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         irq_mask <= 2'h0;
      else if (wr && hit_mask)
         irq_mask <= pwdata_i[1:0];
   end

   assign irq_o = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         prdata_o <= 32'h0000_0000;
         if (is_backup)
            prdata_o[DATA_W-1:0] <= backup[backup_idx];
         else if (hit_ctrl)
         begin
            prdata_o[BIT_PIN_ENABLE] <= pin_enable;
            prdata_o[BIT_POLARITY]   <= polarity;
         end
         else if (hit_cs)
         begin
            prdata_o[BIT_IRQ_ENABLE] <= irq_enable;
            prdata_o[BIT_EVENT_FLAG] <= event_flag;
            prdata_o[BIT_IRQ_FLAG]   <= irq_flag;
         end
         else if (hit_st)
            prdata_o[1:0] <= irq_status;
         else if (hit_mask)
            prdata_o[1:0] <= irq_mask;
      end
   end

endmodule

// ---- verif/tamper_checker_properties.sv ----
/* Port checker for the tamper block.
   Assumes APB writes land at the access edge and tracks control bits itself. */
module tamper_checker
   import tamper_pkg::*;
#(
   parameter int NUM_REGS = NUM_BACKUP
)
(
   input wire logic        ref_clk_i,
   input wire logic        nrst_i,
   input wire logic        nrst_backup_i,
   input wire logic        standby_exit_i,
   input wire logic        pin_output_busy_i,
   input wire logic        tamper_pin_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        pin_gpio_free_o,
   input wire logic        tamper_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en, pol, ien;
   wire  wr  = psel_i && penable_i && pwrite_i;
   wire  rd  = psel_i && !penable_i && !pwrite_i;
   wire  sts = paddr_i == ADDR_TAMPER_CTRL_STS;
   wire  act = en && !pin_output_busy_i && (tamper_pin_i ^ pol);
   wire  set = act && ien;
   wire  clr = standby_exit_i || (wr && sts && pwdata_i[BIT_IRQ_CLEAR]);
   wire  bk  = paddr_i >= ADDR_BACKUP_FIRST && int'(paddr_i) < 4 + 4 * NUM_REGS;
   always_ff @(posedge ref_clk_i)
      if (!nrst_backup_i)
         {en, pol, ien} <= 3'h0;
      else if (wr && paddr_i == ADDR_TAMPER_CONTROL)
         {pol, en} <= pwdata_i[1:0];
      else if (wr && sts)
         ien <= pwdata_i[BIT_IRQ_ENABLE];
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i || !nrst_backup_i);
   property p_err; psel_i && penable_i && paddr_i == 12'h0AC |-> pslverr_o && pready_o; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_gpio; pin_gpio_free_o == !en; endproperty
   a_gpio: assert property (p_gpio) else $error("pin release wrong");
   property p_set; set |=> tamper_irq_o; endproperty
   a_set: assert property (p_set) else $error("irq flag not set");
   property p_quiet; !tamper_irq_o && !set |=> !tamper_irq_o; endproperty
   a_quiet: assert property (p_quiet) else $error("irq flag set wrongly");
   property p_hold; tamper_irq_o && !clr |=> tamper_irq_o; endproperty
   a_hold: assert property (p_hold) else $error("irq flag lost");
   property p_clr; clr && !set |=> !tamper_irq_o; endproperty
   a_clr: assert property (p_clr) else $error("irq flag not cleared");
   property p_evt; rd && sts && $past(act) |=> prdata_o[BIT_EVENT_FLAG]; endproperty
   a_evt: assert property (p_evt) else $error("event flag not read");
   property p_bk; rd && bk && $past(act) |=> prdata_o == 32'h0; endproperty
   a_bk: assert property (p_bk) else $error("backup not cleared");
   c_set: cover property (set);
   c_stby: cover property (standby_exit_i && tamper_irq_o);
   c_err: cover property (pslverr_o);
endmodule
bind tamper_detect_backup_clear tamper_checker #(.NUM_REGS(NUM_REGS)) u_chk (.*);

// ---- verif/tamper_switch.sv ----
/* Tamper switch on the tamper pin.
   Assumes the bench sets its closed state and active level. */
module tamper_switch
(
   input  wire logic closed_i,
   input  wire logic active_low_i,
   output logic      pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_o = closed_i ^ active_low_i;
endmodule

// ---- verif/tb.sv ----
/* Bench for the tamper block: APB transfers and directed tests.
   Assumes the package, switch model and checker are compiled first. */
module tb
   import tamper_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] ct = ADDR_TAMPER_CONTROL;
   localparam logic [11:0] st = ADDR_TAMPER_CTRL_STS;
   localparam logic [11:0] b0 = ADDR_BACKUP_FIRST;
   logic ref_clk_i = 1'h0, nrst_i = 1'h0, nrst_backup_i = 1'h0, standby_exit_i = 1'h0;
   logic pin_output_busy_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic closed = 1'h0, low = 1'h0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, pin_gpio_free_o, tamper_irq_o, irq_o, tamper_pin_i;
   int failures = 0, checks = 0;
   always #10 ref_clk_i = ~ref_clk_i;
   tamper_switch u_sw (.closed_i(closed), .active_low_i(low), .pin_o(tamper_pin_i));
   tamper_detect_backup_clear u_dut (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
      // Two idle cycles first, so a pin change from the caller has already landed in the flags
      @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'h1;
      @(posedge ref_clk_i);
      while (pready_o !== 1'h1) @(posedge ref_clk_i);
      if (!w) chk(prdata_o, d);
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask
   task automatic test_done;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      nrst_i <= 1'h1;
      nrst_backup_i <= 1'h1;
      xf(1'h0, ct, 32'h0);
      xf(1'h0, st, 32'h0);
      xf(1'h1, b0, 32'hFFFF_A5C3);
      xf(1'h0, b0, 32'h0000_A5C3);
      xf(1'h0, 12'h0AC, 32'h0);
      closed <= 1'h1;
      xf(1'h0, st, 32'h0);
      chk({31'h0, pin_gpio_free_o}, 32'h1);
      closed <= 1'h0;
      $display("test 1 done");
      xf(1'h1, ADDR_IRQ_MASK, 32'h3);
      for (int p = 0; p < 2; p++)
      begin
         low <= p[0];
         xf(1'h1, ct, {30'h0, p[0], 1'h0});
         xf(1'h1, b0, 32'h0000_00C3);
         xf(1'h1, st, 32'h4);
         xf(1'h1, ct, {30'h0, p[0], 1'h1});
         xf(1'h0, st, 32'h4);
         closed <= 1'h1;
         xf(1'h0, st, 32'h304);
         xf(1'h0, b0, 32'h0);
         chk({30'h0, tamper_irq_o, irq_o}, 32'h3);
         closed <= 1'h0;
         xf(1'h1, st, 32'h6);
         xf(1'h0, st, 32'h104);
         xf(1'h1, st, 32'h5);
         xf(1'h0, st, 32'h4);
         xf(1'h1, ADDR_IRQ_STATUS, 32'h3);
         @(posedge ref_clk_i);
         chk({31'h0, irq_o}, 32'h0);
         xf(1'h1, ct, {30'h0, p[0], 1'h0});
      end
      $display("test 2 done");
      xf(1'h1, ADDR_IRQ_MASK, 32'h0);
      xf(1'h1, st, 32'h0);
      xf(1'h1, ct, 32'h3);
      closed <= 1'h1;
      xf(1'h0, st, 32'h100);
      chk({30'h0, tamper_irq_o, irq_o}, 32'h0);
      closed <= 1'h0;
      xf(1'h1, st, 32'h5);
      pin_output_busy_i <= 1'h1;
      closed <= 1'h1;
      xf(1'h0, st, 32'h4);
      pin_output_busy_i <= 1'h0;
      xf(1'h0, st, 32'h304);
      closed <= 1'h0;
      @(posedge ref_clk_i);
      standby_exit_i <= 1'h1;
      @(posedge ref_clk_i);
      standby_exit_i <= 1'h0;
      xf(1'h0, st, 32'h104);
      $display("test 3 done");
      test_done();
   end
   initial
   begin
      repeat (5000) @(posedge ref_clk_i);
      failures++;
      test_done();
   end
endmodule
